// ---- sac_pkg.sv ----
// Constants, types and register map of the security alarm and lifecycle controller
// Summary of operation
// - Latch every detector event into status
// - Reset reaction resets chip on event
// - Flag reaction sets status bit and raises fast interrupt, no chip reset
// - Seven detector alarm sources are monitored
// - Tamper stops operation: reset or fast interrupt
// - Invalid address access raises fast interrupt
// - Forbidden code execution in EEPROM raises interrupt
// - Security register writes need privileged access
// - Accesses to prohibited areas are trapped
// - All registers take defaults at power-on
// - Partition memory, restrict user mode accesses
// - Access decisions depend on privileged/user mode
// - Normal mode is permanent, never back
// - Test entry needs correct authentication password
// - Test commands rejected once in normal mode
// - Clock and reset pads are glitch filtered
// - Detection always on; only reaction configurable
package sac_pkg;

	// Event bit positions in status, clear and enable
	localparam int NDET = 7;
	localparam int EV_FREQ = 0;
	localparam int EV_BADADDR = 7;
	localparam int EV_EXEC = 8;
	localparam int EV_MPU = 9;
	localparam int EV_REGTRAP = 10;
	localparam int NEV = 11;
	localparam int NREG = 4;

	// Register byte offsets
	localparam logic [7:0] ADR_STATUS = 8'h00;
	localparam logic [7:0] ADR_CLEAR = 8'h04;
	localparam logic [7:0] ADR_ENABLE = 8'h08;
	localparam logic [7:0] ADR_REACT = 8'h0C;
	localparam logic [7:0] ADR_LIFE = 8'h10;
	localparam logic [7:0] ADR_REGION0 = 8'h20;

	// Region word fields: base page, limit page, user read/write/exec
	localparam int RG_BASE_LSB = 0;
	localparam int RG_LIM_LSB = 8;
	localparam int RG_R = 16;
	localparam int RG_W = 17;
	localparam int RG_X = 18;
	localparam int REACT_RESET = 0;

	// Memory map in 256-byte pages
	localparam logic [7:0] MEM_TOP_PG = 8'hEF;
	localparam logic [7:0] EE_LO_PG = 8'h80;
	localparam logic [7:0] EE_HI_PG = 8'hBF;

	// Timing, clock at 40 MHz
	localparam int CLK_PERIOD_PS = 25000;
	localparam int RSTF_NS = 100;
	localparam int RSTF_CYC = (RSTF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CLKF_MIN_NS = 50;
	localparam int CLKF_CYC = (CLKF_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CHIP_RST_NS = 200;
	localparam int CHIP_RST_CYC = (CHIP_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// Test port commands
	localparam logic [1:0] TCMD_AUTH = 2'h0;
	localparam logic [1:0] TCMD_FTEST = 2'h1;
	localparam logic [1:0] TCMD_NORMAL = 2'h2;

	typedef enum logic [1:0] {
		LC_LOCKED = 2'b00,
		LC_TEST = 2'b01,
		LC_NORMAL = 2'b10
	} sac_life_t;

	typedef struct packed {
		logic valid;
		logic priv;
		logic fetch;
		logic write;
		logic [15:0] addr;
	} sac_cpu_acc_t;

	typedef struct packed {
		logic valid;
		logic [1:0] cmd;
		logic [31:0] data;
	} sac_tcmd_t;

endpackage

// ---- sac_ctrl.sv ----
// Security alarm, access control and lifecycle controller with Wishbone slave
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module sac_ctrl
	import sac_pkg::*;
#(
	parameter logic [31:0] TEST_PASSWORD = 32'h1234_5678 // Arbitrary value
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_priv_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [NDET-1:0] det_i,
	input wire logic ext_clk_i,
	input wire logic ext_rst_i,
	input wire sac_cpu_acc_t cpu_acc_i,
	input wire sac_tcmd_t tcmd_i,
	input wire logic nvm_normal_i,
	output logic irq_o,
	output logic fast_interrupt_request_o,
	output logic chip_rst_o,
	output logic acc_trap_o,
	output logic clk_filt_o,
	output logic tst_ok_o,
	output logic tst_rej_o,
	output logic ftest_start_o,
	output logic fuse_prog_o,
	output logic test_mode_o
);

	// Region hit on a page, used by several checks
	function automatic logic rg_hit(input logic [31:0] rg, input logic [7:0] pg);
		rg_hit = (pg >= rg[RG_BASE_LSB +: 8]) && (pg <= rg[RG_LIM_LSB +: 8]);
	endfunction

	localparam logic [3:0] RSTF_MAX = 4'(RSTF_CYC);
	localparam logic [3:0] CLKF_MIN = 4'(CLKF_CYC);
	localparam logic [3:0] CHRST_LD = 4'(CHIP_RST_CYC);
	localparam int EV_HI = NEV - 1;

	logic [NEV-1:0] status_r, status_nxt;
	logic [NEV-1:0] enable_r, enable_nxt;
	logic react_r, react_nxt;
	logic [31:0] region_r [NREG];
	logic [31:0] region_nxt [NREG];
	logic ack_r, ack_nxt;
	logic [31:0] dat_r, dat_nxt;
	logic irq_r, irq_nxt;
	logic fast_int_r, fast_int_nxt;
	logic [3:0] chrst_cnt_r, chrst_cnt_nxt;
	logic chrst_r, chrst_nxt;
	logic [3:0] rstf_cnt_r, rstf_cnt_nxt;
	logic trap_r, trap_nxt;
	logic clk_smp_r, clk_smp_nxt;
	logic clk_filt_r, clk_filt_nxt;
	logic [3:0] clk_cnt_r, clk_cnt_nxt;
	logic hf_ev;
	sac_life_t life_r, life_nxt;
	logic strap_done_r, strap_done_nxt;
	logic tok_r, tok_nxt;
	logic trej_r, trej_nxt;
	logic ftest_r, ftest_nxt;
	logic fuse_r, fuse_nxt;
	logic tmode_r, tmode_nxt;
	logic [NEV-1:0] ev;
	logic [NDET-1:0] det_ev;
	logic bus_req, bus_wr, wr_ok;
	logic [7:0] pg;
	logic user_ok, bad_addr, exec_viol, mpu_viol;

	// Wishbone handshake: one-cycle ack, request acted on when ack rises
	assign bus_req = wb_cyc_i && wb_stb_i && !ack_r;
	assign bus_wr = bus_req && wb_we_i;
	assign wr_ok = bus_wr && wb_priv_i;

	// Clock pad filter; a phase shorter than the minimum is a frequency alarm
	always_comb begin
		clk_smp_nxt = ext_clk_i;
		clk_cnt_nxt = clk_cnt_r;
		clk_filt_nxt = clk_filt_r;
		hf_ev = 1'b0;
		if (clk_smp_r != clk_filt_r) begin
			if (clk_cnt_r + 4'h1 >= CLKF_MIN) begin
				clk_filt_nxt = clk_smp_r;
				clk_cnt_nxt = 4'h0;
			end else begin
				clk_cnt_nxt = clk_cnt_r + 4'h1;
			end
		end else begin
			if (clk_cnt_r != 4'h0 && clk_cnt_r < CLKF_MIN) begin
				hf_ev = 1'b1;
			end
			clk_cnt_nxt = 4'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// Track the pad in reset, else a false short phase follows release
			clk_smp_r <= ext_clk_i;
			clk_cnt_r <= 4'h0;
			clk_filt_r <= ext_clk_i;
		end else begin
			clk_smp_r <= clk_smp_nxt;
			clk_cnt_r <= clk_cnt_nxt;
			clk_filt_r <= clk_filt_nxt;
		end
	end

	// Access checks on every CPU access, no software override
	always_comb begin
		pg = cpu_acc_i.addr[15:8];
		user_ok = 1'b0;
		for (int i = 0; i < NREG; i++) begin
			if (rg_hit(region_r[i], pg)) begin
				if (cpu_acc_i.fetch && region_r[i][RG_X]) begin
					user_ok = 1'b1;
				end
				if (!cpu_acc_i.fetch && cpu_acc_i.write && region_r[i][RG_W]) begin
					user_ok = 1'b1;
				end
				if (!cpu_acc_i.fetch && !cpu_acc_i.write && region_r[i][RG_R]) begin
					user_ok = 1'b1;
				end
			end
		end
		bad_addr = cpu_acc_i.valid && (pg > MEM_TOP_PG);
		// User fetch from EEPROM without exec right
		exec_viol = cpu_acc_i.valid && !bad_addr && !cpu_acc_i.priv && cpu_acc_i.fetch
			&& (pg >= EE_LO_PG) && (pg <= EE_HI_PG) && !user_ok;
		mpu_viol = cpu_acc_i.valid && !bad_addr && !cpu_acc_i.priv && !exec_viol && !user_ok;
		trap_nxt = bad_addr || exec_viol || mpu_viol;
	end

	// Event vector; detectors cannot be masked from software
	always_comb begin
		det_ev = det_i;
		det_ev[EV_FREQ] = det_i[EV_FREQ] || hf_ev;
		ev = '0;
		ev[NDET-1:0] = det_ev;
		ev[EV_BADADDR] = bad_addr;
		ev[EV_EXEC] = exec_viol;
		ev[EV_MPU] = mpu_viol;
		ev[EV_REGTRAP] = bus_wr && !wb_priv_i;
	end

	// Register file and interrupt state
	always_comb begin
		status_nxt = status_r;
		enable_nxt = enable_r;
		react_nxt = react_r;
		region_nxt = region_r;
		ack_nxt = bus_req;
		dat_nxt = '0;
		if (wr_ok && wb_sel_i[0]) begin
			if (wb_adr_i == ADR_CLEAR) begin
				status_nxt = status_r & ~wb_dat_i[EV_HI:0];
			end
		end
		status_nxt = status_nxt | ev;
		if (wr_ok) begin
			unique case (wb_adr_i)
				ADR_ENABLE: begin
					if (wb_sel_i[0]) enable_nxt[7:0] = wb_dat_i[7:0];
					if (wb_sel_i[1]) enable_nxt[EV_HI:8] = wb_dat_i[EV_HI:8];
				end
				ADR_REACT: begin
					if (wb_sel_i[0]) react_nxt = wb_dat_i[REACT_RESET];
				end
				default: begin
					for (int i = 0; i < NREG; i++) begin
						if (wb_adr_i == ADR_REGION0 + 8'(4 * i)) begin
							for (int b = 0; b < 3; b++) begin
								if (wb_sel_i[b]) region_nxt[i][8*b +: 8] = wb_dat_i[8*b +: 8];
							end
						end
					end
				end
			endcase
		end
		if (bus_req && !wb_we_i) begin
			unique case (wb_adr_i)
				ADR_STATUS: dat_nxt[EV_HI:0] = status_r;
				ADR_ENABLE: dat_nxt[EV_HI:0] = enable_r;
				ADR_REACT: dat_nxt[REACT_RESET] = react_r;
				ADR_LIFE: dat_nxt[1:0] = life_r;
				default: begin
					for (int i = 0; i < NREG; i++) begin
						if (wb_adr_i == ADR_REGION0 + 8'(4 * i)) begin
							dat_nxt = region_r[i] & 32'h0007_FFFF;
						end
					end
				end
			endcase
		end
		irq_nxt = |(status_nxt & enable_nxt);
		// Tamper alarm in flag mode raises fast interrupt
		fast_int_nxt = status_nxt[EV_BADADDR] || status_nxt[EV_EXEC] || status_nxt[EV_MPU]
			|| (!react_nxt && |status_nxt[NDET-1:0]);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_r <= '0;
			enable_r <= '0;
			react_r <= 1'b1;
			for (int i = 0; i < NREG; i++) begin
				region_r[i] <= 32'h0000_0000;
			end
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
			irq_r <= 1'b0;
			fast_int_r <= 1'b0;
			trap_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			enable_r <= enable_nxt;
			react_r <= react_nxt;
			region_r <= region_nxt;
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
			irq_r <= irq_nxt;
			fast_int_r <= fast_int_nxt;
			trap_r <= trap_nxt;
		end
	end

	// Chip reset: filtered pad reset or detector reaction
	always_comb begin
		rstf_cnt_nxt = ext_rst_i ? rstf_cnt_r : 4'h0;
		// Reset pad must hold to count
		if (ext_rst_i && rstf_cnt_r < RSTF_MAX) begin
			rstf_cnt_nxt = rstf_cnt_r + 4'h1;
		end
		chrst_cnt_nxt = (chrst_cnt_r != 4'h0) ? chrst_cnt_r - 4'h1 : 4'h0;
		if (react_r && |det_ev) begin
			chrst_cnt_nxt = CHRST_LD;
		end
		chrst_nxt = (chrst_cnt_nxt != 4'h0) || (rstf_cnt_nxt == RSTF_MAX);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rstf_cnt_r <= 4'h0;
			chrst_cnt_r <= 4'h0;
			chrst_r <= 1'b1;
		end else begin
			rstf_cnt_r <= rstf_cnt_nxt;
			chrst_cnt_r <= chrst_cnt_nxt;
			chrst_r <= chrst_nxt;
		end
	end

	// Lifecycle: fuse sampled once after reset release, then commands
	always_comb begin
		life_nxt = life_r;
		strap_done_nxt = 1'b1;
		tok_nxt = 1'b0;
		trej_nxt = 1'b0;
		ftest_nxt = 1'b0;
		fuse_nxt = 1'b0;
		if (!strap_done_r) begin
			life_nxt = nvm_normal_i ? LC_NORMAL : LC_LOCKED;
		end else if (tcmd_i.valid) begin
			unique case (life_r)
				LC_LOCKED: begin
					if (tcmd_i.cmd == TCMD_AUTH && tcmd_i.data == TEST_PASSWORD) begin
						life_nxt = LC_TEST;
						tok_nxt = 1'b1;
					end else begin
						trej_nxt = 1'b1;
					end
				end
				LC_TEST: begin
					tok_nxt = 1'b1;
					if (tcmd_i.cmd == TCMD_FTEST) begin
						ftest_nxt = 1'b1;
					end else if (tcmd_i.cmd == TCMD_NORMAL) begin
						life_nxt = LC_NORMAL;
						fuse_nxt = 1'b1;
					end
				end
				LC_NORMAL: trej_nxt = 1'b1;
				default: begin
					life_nxt = LC_NORMAL;
					trej_nxt = 1'b1;
				end
			endcase
		end
		tmode_nxt = (life_nxt == LC_TEST);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			life_r <= LC_LOCKED;
			strap_done_r <= 1'b0;
			tok_r <= 1'b0;
			trej_r <= 1'b0;
			ftest_r <= 1'b0;
			fuse_r <= 1'b0;
			tmode_r <= 1'b0;
		end else begin
			life_r <= life_nxt;
			strap_done_r <= strap_done_nxt;
			tok_r <= tok_nxt;
			trej_r <= trej_nxt;
			ftest_r <= ftest_nxt;
			fuse_r <= fuse_nxt;
			tmode_r <= tmode_nxt;
		end
	end

	assign wb_dat_o = dat_r;
	assign wb_ack_o = ack_r;
	assign irq_o = irq_r;
	assign fast_interrupt_request_o = fast_int_r;
	assign chip_rst_o = chrst_r;
	assign acc_trap_o = trap_r;
	assign clk_filt_o = clk_filt_r;
	assign tst_ok_o = tok_r;
	assign tst_rej_o = trej_r;
	assign ftest_start_o = ftest_r;
	assign fuse_prog_o = fuse_r;
	assign test_mode_o = tmode_r;

	// Checks on the design's own outputs and internal registers
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_det_latch: assert property (det_i[3] |=> status_r[3])
		else $error("detector event not latched");
	a_react_reset: assert property (react_r && |det_i |=> chip_rst_o [*4])
		else $error("reset reaction missing");
	a_flag_norst: assert property (!react_r && det_i[2] && !$past(chrst_r)
		&& chrst_cnt_r == 4'h0 && rstf_cnt_r == 4'h0 && !ext_rst_i
		|=> !chip_rst_o ##0 fast_interrupt_request_o)
		else $error("flag reaction reset chip");
	a_bad_fiq: assert property (bad_addr |=> fast_interrupt_request_o && acc_trap_o)
		else $error("invalid address not trapped");
	a_exec_fiq: assert property (exec_viol |=> status_r[EV_EXEC] && fast_interrupt_request_o)
		else $error("exec violation missed");
	a_user_wr: assert property (bus_wr && !wb_priv_i && wb_adr_i == ADR_REACT
		|=> $stable(react_r) && status_r[EV_REGTRAP])
		else $error("unprivileged write took effect");
	a_priv_pass: assert property (cpu_acc_i.valid && cpu_acc_i.priv
		&& pg <= MEM_TOP_PG |=> !acc_trap_o)
		else $error("privileged access trapped");
	a_normal_stay: assert property (life_r == LC_NORMAL |=> life_r == LC_NORMAL)
		else $error("left normal mode");
	a_pw_needed: assert property (strap_done_r && life_r == LC_LOCKED
		&& $stable(life_r) && tcmd_i.valid && tcmd_i.data != TEST_PASSWORD
		|=> life_r != LC_TEST ##0 tst_rej_o)
		else $error("test entry without password");
	a_normal_rej: assert property (strap_done_r && life_r == LC_NORMAL
		&& tcmd_i.valid |=> tst_rej_o && !ftest_start_o)
		else $error("test command accepted in normal");
	a_flag_hold: assert property (status_r[4]
		&& !(wr_ok && wb_adr_i == ADR_CLEAR) |=> status_r[4])
		else $error("flag dropped without clear");

endmodule

// ---- test_sac_ctrl.sv ----
// Self-checking bench for the security alarm and lifecycle controller
`timescale 1ns/1ps
module test_sac_ctrl
	import sac_pkg::*;
;
	// Arbitrary password, differs from the design default on purpose
	localparam logic [31:0] PW = 32'hA5C3_0F96;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, priv = 0;
	logic ext_clk = 0, ext_rst = 0, nvm = 0, glt = 0, clk_run = 1;
	logic [7:0] adr = '0;
	logic [31:0] wdat = '0;
	logic [6:0] det = '0;
	sac_cpu_acc_t acc = '0;
	sac_tcmd_t tc = '0;
	logic [31:0] rdat, q;
	logic ack, irq, fast_int, crst, trap, cfilt, tok, trej, fts, fuse, tmode;
	int n_errors = 0, n_checks = 0;

	sac_ctrl #(.TEST_PASSWORD(PW)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
		.wb_priv_i(priv), .wb_dat_o(rdat), .wb_ack_o(ack), .det_i(det),
		.ext_clk_i(ext_clk ^ glt), .ext_rst_i(ext_rst), .cpu_acc_i(acc), .tcmd_i(tc),
		.nvm_normal_i(nvm), .irq_o(irq), .fast_interrupt_request_o(fast_int),
		.chip_rst_o(crst), .acc_trap_o(trap),
		.clk_filt_o(cfilt), .tst_ok_o(tok), .tst_rej_o(trej), .ftest_start_o(fts),
		.fuse_prog_o(fuse), .test_mode_o(tmode));

	// System clock, 25 ns period
	always #12.5 clk_i = ~clk_i;

	// Slow clean pad clock, phases well above the filter limit
	always begin
		repeat (4) @(posedge clk_i);
		if (clk_run) ext_clk <= ~ext_clk;
	end

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Classic single cycle; waits for ack, no fixed latency assumed
	task wbx(input logic w, input logic [7:0] a, input logic [31:0] d, input logic p);
		int t;
		t = 0;
		@(posedge clk_i);
		cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; priv <= p;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack !== 1'b1 && t < 50);
		if (t >= 50) chk("wb ack", 1, 0);
		q = rdat;
		cyc <= 0; stb <= 0; we <= 0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		wbx(0, a, 0, 1);
		chk(nm, e, q);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d, input logic p);
		wbx(1, a, d, p);
	endtask

	// One CPU access, trap pulse looked at in its only cycle
	task cpu(input logic p, f, w, input logic [15:0] a, input logic e);
		@(posedge clk_i);
		acc <= '{1'b1, p, f, w, a};
		@(posedge clk_i);
		acc.valid <= 1'b0;
		@(posedge clk_i);
		chk("trap", e, trap);
	endtask

	// Test port command; e = {ok, rej, ftest, fuse}
	task tcmd(input logic [1:0] c, input logic [31:0] d, input logic [3:0] e);
		@(posedge clk_i);
		tc <= '{1'b1, c, d};
		@(posedge clk_i);
		tc.valid <= 1'b0;
		@(posedge clk_i);
		chk("test port", e, {tok, trej, fts, fuse});
	endtask

	task pulse_det(input int k);
		@(posedge clk_i);
		det <= 7'(1 << k);
		@(posedge clk_i);
		det <= '0;
		repeat (3) @(posedge clk_i);
	endtask

	task tally_and_finish;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Watchdog, the sequence needs a few thousand cycles at most
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		tally_and_finish;
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		rd(ADR_STATUS, 0, "status");
		rd(ADR_ENABLE, 0, "enable");
		rd(ADR_REACT, 1, "react");
		rd(ADR_LIFE, 0, "life");
		rd(8'h40, 0, "unmapped");
		chk("chip reset", 0, crst);
		$display("test defaults done");
		wr(ADR_REACT, 0, 1);
		wr(ADR_ENABLE, 32'h0000_07FF, 1);
		rd(ADR_ENABLE, 32'h0000_07FF, "enable");
		for (int k = 0; k < NDET; k++) begin
			pulse_det(k);
			rd(ADR_STATUS, 32'(1) << k, "status det");
			chk("fast int flag", 1, fast_int);
			chk("irq", 1, irq);
			chk("no reset", 0, crst);
			wr(ADR_CLEAR, 32'(1) << k, 1);
			repeat (2) @(posedge clk_i);
			chk("fast int clear", 0, fast_int);
		end
		// Masked source still latches: detection cannot be switched off
		wr(ADR_ENABLE, 0, 1);
		pulse_det(3);
		chk("irq masked", 0, irq);
		rd(ADR_STATUS, 32'h0000_0008, "status masked");
		wr(ADR_CLEAR, 32'h0000_07FF, 1);
		wr(ADR_ENABLE, 32'h0000_07FF, 1);
		$display("test flag reaction done");
		wr(ADR_REACT, 1, 0);
		rd(ADR_REACT, 0, "react kept");
		rd(ADR_STATUS, 32'h0000_0400, "reg trap");
		wr(ADR_STATUS, 32'h0000_0000, 1);
		rd(ADR_STATUS, 32'h0000_0400, "status ro");
		wr(ADR_CLEAR, 32'h0000_07FF, 1);
		cpu(0, 0, 0, 16'hF000, 1);
		cpu(1, 0, 0, 16'hF123, 1);
		rd(ADR_STATUS, 32'h0000_0080, "bad addr");
		chk("fast int addr", 1, fast_int);
		wr(ADR_CLEAR, 32'h0000_07FF, 1);
		cpu(0, 1, 0, 16'h8000, 1);
		cpu(1, 1, 0, 16'h8000, 0);
		rd(ADR_STATUS, 32'h0000_0100, "exec");
		chk("fast int exec", 1, fast_int);
		wr(ADR_CLEAR, 32'h0000_07FF, 1);
		wr(ADR_REGION0, 32'h0001_1F10, 1);
		rd(ADR_REGION0, 32'h0001_1F10, "region");
		cpu(0, 0, 0, 16'h1234, 0);
		cpu(0, 0, 1, 16'h1234, 1);
		cpu(0, 0, 0, 16'h2000, 1);
		cpu(1, 0, 1, 16'h1234, 0);
		rd(ADR_STATUS, 32'h0000_0200, "mpu");
		wr(ADR_CLEAR, 32'h0000_07FF, 1);
		$display("test access control done");
		wr(ADR_REACT, 1, 1);
		pulse_det(2);
		chk("det reset", 1, crst);
		chk("no fast int", 0, fast_int);
		repeat (12) @(posedge clk_i);
		chk("reset end", 0, crst);
		rd(ADR_STATUS, 32'h0000_0004, "sticky");
		wr(ADR_CLEAR, 32'h0000_07FF, 1);
		// Short pad pulse must be swallowed, a long one passes
		@(posedge clk_i);
		ext_rst <= 1;
		repeat (2) @(posedge clk_i);
		ext_rst <= 0;
		repeat (6) @(posedge clk_i);
		chk("rst glitch", 0, crst);
		ext_rst <= 1;
		repeat (8) @(posedge clk_i);
		chk("rst pad", 1, crst);
		ext_rst <= 0;
		repeat (14) @(posedge clk_i);
		chk("rst pad end", 0, crst);
		// Hold the pad clock still so a lone glitch makes a short phase
		clk_run <= 0;
		repeat (8) @(posedge clk_i);
		chk("pad clock", ext_clk, cfilt);
		glt <= 1;
		@(posedge clk_i);
		glt <= 0;
		repeat (4) @(posedge clk_i);
		chk("clk glitch", ext_clk, cfilt);
		chk("freq reset", 1, crst);
		rd(ADR_STATUS, 32'h0000_0001, "freq alarm");
		wr(ADR_CLEAR, 32'h0000_07FF, 1);
		clk_run <= 1;
		$display("test reset reaction done");
		tcmd(TCMD_FTEST, 0, 4'b0100);
		tcmd(TCMD_AUTH, PW ^ 32'h0000_0001, 4'b0100);
		chk("locked", 0, tmode);
		tcmd(TCMD_AUTH, PW, 4'b1000);
		chk("test mode", 1, tmode);
		rd(ADR_LIFE, 1, "life test");
		tcmd(TCMD_FTEST, 0, 4'b1010);
		tcmd(TCMD_NORMAL, 0, 4'b1001);
		rd(ADR_LIFE, 2, "life normal");
		for (int c = 0; c < 3; c++) begin
			tcmd(2'(c), PW, 4'b0100);
			chk("no test", 0, tmode);
		end
		// Power-on again with the fuse blown
		@(posedge clk_i);
		nvm <= 1;
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		rd(ADR_LIFE, 2, "life fuse");
		rd(ADR_REGION0, 0, "region por");
		rd(ADR_STATUS, 0, "status por");
		tcmd(TCMD_AUTH, PW, 4'b0100);
		$display("test lifecycle done");
		tally_and_finish;
	end
endmodule
